// ---- include/lmr_pkg.sv ----
// lmr_pkg: constants, types and the contract for the line mode and ring detect control block
// assumes one 20 MHz clock and a plain register port driven by the host serial port logic
package lmr_pkg;

  // ******************************
  // register map
  // ******************************
  localparam logic [7:0] LMR_HOOK_OFS = 8'h05;
  localparam logic [7:0] LMR_CTRL_OFS = 8'h12;
  localparam logic [7:0] LMR_SENSE_OFS = 8'h13;
  localparam logic [7:0] LMR_STAT_OFS = 8'h14;

  // hook register fields
  localparam int LMR_HOOK_BIT = 0;
  localparam int LMR_ONHOOK_MONITOR_ENABLE_BIT = 1;
  localparam int LMR_RZH_BIT = 2;
  // control register fields
  localparam int LMR_SQL_BIT = 0;
  localparam int LMR_RECT_BIT = 1;
  localparam int LMR_MODE_BIT = 2;
  // sense register field
  localparam int LMR_SENSE_LSB = 3;
  // status register fields
  localparam int LMR_STATE_LSB = 0;
  localparam int LMR_SQMET_BIT = 2;

  localparam logic [7:0] LMR_HOOK_RST = 8'h00;
  localparam logic [7:0] LMR_CTRL_RST = 8'h00;
  localparam logic [4:0] LMR_SENSE_ONES = 5'h1F;
  localparam logic [4:0] LMR_SENSE_ZERO = 5'h00;

  // ******************************
  // timing
  // ******************************
  localparam int LMR_CLK_HZ = 20_000_000;
  localparam int LMR_SQ_MIN_US = 1000;
  localparam int LMR_SQ_MIN_CYC = (LMR_SQ_MIN_US * (LMR_CLK_HZ / 1_000_000));

  // ******************************
  // types
  // ******************************
  typedef enum logic [1:0] {
    LMR_ONHOOK = 2'b00,
    LMR_FORCE_ONHOOK = 2'b01,
    LMR_OFFHOOK = 2'b10,
    LMR_FAST_DCT = 2'b11
  } lmr_line_e;

  typedef enum logic [2:0] {
    LMR_SRC_NONE = 3'b000,
    LMR_SRC_RING = 3'b001,
    LMR_SRC_LINE = 3'b010,
    LMR_SRC_MON_LOW = 3'b011,
    LMR_SRC_MON_HIGH = 3'b100
  } lmr_src_e;

  typedef struct packed {
    logic ring_event;
    logic line_present;
    logic [4:0] line_voltage;
    logic [4:0] loop_current;
    logic [4:0] monitor_low;
  } lmr_sense_s;

endpackage : lmr_pkg

// ---- verif/lmr_host_model.sv ----
// lmr_host_model: host that reads and writes the control registers
// assumes the lmr_ctrl register port: one-cycle strobes, read data one cycle later
`timescale 1ns/100ps
`default_nettype none

module lmr_host_model (
  // clock
  input wire logic clk_sys,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    // read data stands only in the cycle after the strobe; take it at that cycle's end
    @(posedge clk_sys);
    d = reg_rdata;
  endtask : rd

  // monitor bit cleared in the same write that sets hook, mode written next, monitor set last
  task automatic set_line(input logic m, input logic h, input logic o);
    wr(8'h05, {7'h00, h});
    wr(8'h12, {5'h00, m, 2'b00});
    if (o)
      wr(8'h05, {6'h00, o, h});
  endtask : set_line
endmodule : lmr_host_model

`default_nettype wire

// ---- verif/tb.sv ----
// tb: self-checking bench for lmr_ctrl
// assumes lmr_pkg and the host model; squelch count shortened to SQ cycles
`timescale 1ns/100ps
`default_nettype none

module tb;
  import lmr_pkg::*;
  localparam int SQ = 8;
  logic clk_sys, rst, reg_wr, reg_rd, ring_inputs_pos, ring_inputs_neg;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  lmr_sense_s sense_in;
  lmr_line_e line_state;
  lmr_src_e serial_src;
  logic serial_data_out, ring_detect_pin, ring_squelch_en, tx_quiet, offhook_restart;
  logic [9:0] ex;
  int failures = 0;
  int checks_done = 0;
  int pulses = 0;
  int cycles = 0;

  lmr_ctrl #(.SQ_MIN_CYC(SQ)) dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sense_in(sense_in), .ring_inputs_pos(ring_inputs_pos), .ring_inputs_neg(ring_inputs_neg),
    .line_state(line_state), .serial_src(serial_src), .serial_data_out(serial_data_out),
    .ring_detect_pin(ring_detect_pin), .ring_squelch_en(ring_squelch_en),
    .tx_quiet(tx_quiet), .offhook_restart(offhook_restart));
  lmr_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (offhook_restart === 1'b1)
      pulses <= pulses + 1;
    if (cycles == 6000) begin
      failures++;
      results();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic results;
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // state, source and sense per {mode, hook, monitor} with voltage 0A, current 15, monitor 06
  function automatic logic [9:0] row(input logic [2:0] c);
    case (c)
      3'h0: return {LMR_ONHOOK, LMR_SRC_NONE, 5'h00};
      3'h1: return {LMR_ONHOOK, LMR_SRC_MON_HIGH, 5'h1F};
      3'h2: return {LMR_OFFHOOK, LMR_SRC_LINE, 5'h15};
      3'h3: return {LMR_FAST_DCT, LMR_SRC_LINE, 5'h15};
      3'h4: return {LMR_ONHOOK, LMR_SRC_RING, 5'h0A};
      3'h5: return {LMR_ONHOOK, LMR_SRC_MON_LOW, 5'h06};
      3'h6: return {LMR_FORCE_ONHOOK, LMR_SRC_NONE, 5'h0A};
      default: return {LMR_FORCE_ONHOOK, LMR_SRC_MON_LOW, 5'h0A};
    endcase
  endfunction : row

  initial begin
    rst = 1'b1;
    ring_inputs_pos = 1'b0;
    ring_inputs_neg = 1'b0;
    sense_in = {1'b0, 1'b1, 5'h0A, 5'h15, 5'h06};
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    // ******************************
    // reset values and refused accesses
    // ******************************
    host.rd(8'h05, d); chk(d, 8'h00, "hook reset");
    host.rd(8'h12, d); chk(d, 8'h00, "ctrl reset");
    host.rd(8'h00, d); chk(d, 8'h00, "unmapped read");
    host.wr(8'h12, 8'hF8);
    host.rd(8'h12, d); chk(d, 8'h00, "ctrl high bits");
    // ******************************
    // decode of all eight control combinations
    // ******************************
    for (int c = 0; c < 8; c++) begin
      ex = row(c[2:0]);
      host.set_line(c[2], c[1], c[0]);
      repeat (3) @(posedge clk_sys);
      chk({6'h00, line_state}, {6'h00, ex[9:8]}, "line state");
      chk({5'h00, serial_src}, {5'h00, ex[7:5]}, "source");
      chk({7'h00, tx_quiet}, {7'h00, c == 3}, "tx quiet");
      host.rd(8'h13, d); chk(d, {ex[4:0], 3'h0}, "sense");
      host.rd(8'h14, d); chk({6'h00, d[1:0]}, {6'h00, ex[9:8]}, "status");
    end
    // ******************************
    // ring event with hook set
    // ******************************
    host.set_line(0, 1, 0);
    host.wr(8'h05, 8'h05);
    sense_in <= {1'b1, 1'b1, 5'h0A, 5'h15, 5'h06};
    host.rd(8'h13, d); chk(d, 8'hF8, "ring ones");
    sense_in <= {1'b1, 1'b0, 5'h0A, 5'h15, 5'h06};
    host.rd(8'h13, d); chk(d, 8'h00, "ring zeroes");
    // ******************************
    // off-hook restart only from plain on-hook
    // ******************************
    host.set_line(0, 0, 0);
    repeat (3) @(posedge clk_sys);
    pulses = 0;
    host.set_line(0, 1, 0);
    repeat (3) @(posedge clk_sys);
    chk(pulses[7:0], 8'h01, "restart pulse");
    host.set_line(1, 1, 0);
    host.set_line(0, 1, 0);
    repeat (3) @(posedge clk_sys);
    chk(pulses[7:0], 8'h01, "no restart");
    // ******************************
    // rectifier on ring pin and ring stream
    // ******************************
    host.set_line(1, 0, 0);
    ring_inputs_neg <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      host.wr(8'h12, {6'h01, r[0], 1'b0});
      repeat (3) @(posedge clk_sys);
      chk({7'h00, ring_detect_pin}, {7'h00, r[0]}, "ring pin");
      chk({7'h00, serial_data_out}, {7'h00, r[0]}, "ring stream");
    end
    ring_inputs_pos <= 1'b1;
    host.wr(8'h12, 8'h04);
    repeat (3) @(posedge clk_sys);
    chk({7'h00, ring_detect_pin}, 8'h01, "positive lobe");
    // ******************************
    // squelch held then released
    // ******************************
    host.wr(8'h12, 8'h01);
    repeat (2) @(posedge clk_sys);
    chk({7'h00, ring_squelch_en}, 8'h01, "squelch on");
    host.rd(8'h14, d); chk({7'h00, d[2]}, 8'h00, "squelch not yet held");
    repeat (SQ) @(posedge clk_sys);
    host.rd(8'h14, d); chk({7'h00, d[2]}, 8'h01, "squelch held");
    host.wr(8'h12, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk({7'h00, ring_squelch_en}, 8'h00, "squelch off");
    results();
  end
endmodule : tb

`default_nettype wire

// ---- verilog/lmr_ctrl.sv ----
// lmr_ctrl: register bank deciding line state, sense field, ring rectifier and squelch
// assumes synchronous inputs on clk_sys and a host that never strobes read and write together
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module lmr_ctrl
  import lmr_pkg::*;
#(
  parameter int SQ_MIN_CYC = LMR_SQ_MIN_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // line side analog results and ring comparators
  input wire lmr_sense_s sense_in,
  input wire logic ring_inputs_pos,
  input wire logic ring_inputs_neg,
  // line side controls
  output lmr_line_e line_state,
  output lmr_src_e serial_src,
  output logic serial_data_out,
  output logic ring_detect_pin,
  output logic ring_squelch_en,
  output logic tx_quiet,
  output logic offhook_restart
);

  // ******************************
  // register file
  // ******************************
  logic [7:0] hook_q, hook_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] rdata_q, rdata_d;
  logic [4:0] sense_q, sense_d;
  lmr_line_e state_q, state_d;
  logic sq_met_q;

  always_comb begin
    hook_d = hook_q;
    ctrl_d = ctrl_q;
    rdata_d = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        LMR_HOOK_OFS: begin
          hook_d = {5'h00, reg_wdata[2:0]};
        end
        LMR_CTRL_OFS: begin
          ctrl_d = {5'h00, reg_wdata[2:0]};
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        LMR_HOOK_OFS: rdata_d = hook_q;
        LMR_CTRL_OFS: rdata_d = ctrl_q;
        LMR_SENSE_OFS: rdata_d = {sense_q, 3'h0};
        LMR_STAT_OFS: rdata_d = {5'h00, sq_met_q, state_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hook_q <= LMR_HOOK_RST;
      ctrl_q <= LMR_CTRL_RST;
      rdata_q <= 8'h00;
    end else begin
      hook_q <= hook_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  wire logic mode_b = ctrl_q[LMR_MODE_BIT];
  wire logic hook_b = hook_q[LMR_HOOK_BIT];
  wire logic onhook_monitor_enable_b = hook_q[LMR_ONHOOK_MONITOR_ENABLE_BIT];
  wire logic rzh_b = hook_q[LMR_RZH_BIT];

  // ******************************
  // line state decode
  // ******************************
  lmr_src_e src_q, src_d;
  logic restart_q, restart_d;
  logic quiet_q, quiet_d;

  always_comb begin
    // decoded from the live register bits, so a write acts on the next edge
    case ({mode_b, hook_b, onhook_monitor_enable_b})
      3'b000: begin
        state_d = LMR_ONHOOK;
        src_d = LMR_SRC_NONE;
        sense_d = LMR_SENSE_ZERO;
      end
      3'b001: begin
        state_d = LMR_ONHOOK;
        src_d = LMR_SRC_MON_HIGH;
        sense_d = sense_in.line_present ? LMR_SENSE_ONES : LMR_SENSE_ZERO;
      end
      3'b010: begin
        state_d = LMR_OFFHOOK;
        src_d = LMR_SRC_LINE;
        sense_d = sense_in.loop_current;
      end
      3'b011: begin
        state_d = LMR_FAST_DCT;
        src_d = LMR_SRC_LINE;
        sense_d = sense_in.loop_current;
      end
      3'b100: begin
        state_d = LMR_ONHOOK;
        src_d = LMR_SRC_RING;
        sense_d = sense_in.line_voltage;
      end
      3'b101: begin
        state_d = LMR_ONHOOK;
        src_d = LMR_SRC_MON_LOW;
        sense_d = sense_in.monitor_low;
      end
      3'b110: begin
        state_d = LMR_FORCE_ONHOOK;
        src_d = LMR_SRC_NONE;
        sense_d = sense_in.line_voltage;
      end
      default: begin
        state_d = LMR_FORCE_ONHOOK;
        src_d = LMR_SRC_MON_LOW;
        sense_d = sense_in.line_voltage;
      end
    endcase
    // ring indication with ring zero hold set overrides the sense field
    if (rzh_b && sense_in.ring_event) begin
      sense_d = sense_in.line_present ? LMR_SENSE_ONES : LMR_SENSE_ZERO;
    end
    // counter restarts only on leaving plain on-hook, not on leaving force on-hook
    restart_d = (state_q == LMR_ONHOOK) && state_d[1];
    quiet_d = (state_d == LMR_FAST_DCT);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= LMR_ONHOOK;
      src_q <= LMR_SRC_NONE;
      sense_q <= LMR_SENSE_ZERO;
      restart_q <= 1'b0;
      quiet_q <= 1'b0;
    end else begin
      state_q <= state_d;
      src_q <= src_d;
      sense_q <= sense_d;
      restart_q <= restart_d;
      quiet_q <= quiet_d;
    end
  end

  assign line_state = state_q;
  assign serial_src = src_q;
  assign offhook_restart = restart_q;
  assign tx_quiet = quiet_q;

  // ******************************
  // ring rectifier and squelch
  // ******************************
  logic rdet_q, rdet_d;
  logic sdo_q, sdo_d;
  logic sql_q, sql_d;
  logic [15:0] sq_cnt_q, sq_cnt_d;
  logic sq_met_d;

  always_comb begin
    // half wave passes the positive lobe only
    rdet_d = ring_inputs_pos || (ctrl_q[LMR_RECT_BIT] && ring_inputs_neg);
    sdo_d = (src_d == LMR_SRC_RING) ? rdet_d : 1'b0;
    sql_d = ctrl_q[LMR_SQL_BIT];
    // hold time of the squelch bit, reported for software
    sq_cnt_d = sq_cnt_q;
    if (!ctrl_q[LMR_SQL_BIT]) begin
      sq_cnt_d = 16'h0000;
    end else if (!sq_met_q) begin
      sq_cnt_d = sq_cnt_q + 16'h0001;
    end
    sq_met_d = ctrl_q[LMR_SQL_BIT] && (sq_cnt_d >= 16'(SQ_MIN_CYC));
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdet_q <= 1'b0;
      sdo_q <= 1'b0;
      sql_q <= 1'b0;
      sq_cnt_q <= 16'h0000;
      sq_met_q <= 1'b0;
    end else begin
      rdet_q <= rdet_d;
      sdo_q <= sdo_d;
      sql_q <= sql_d;
      sq_cnt_q <= sq_cnt_d;
      sq_met_q <= sq_met_d;
    end
  end

  assign ring_detect_pin = rdet_q;
  assign serial_data_out = sdo_q;
  assign ring_squelch_en = sql_q;

  // ******************************
  // checks
  // ******************************
  chk_onhook_ring_src: assert property (@(posedge clk_sys) disable iff (rst)
    ({mode_b, hook_b, onhook_monitor_enable_b} == 3'b100) |=> (src_q == LMR_SRC_RING) && (state_q == LMR_ONHOOK))
    else $error("ring data not selected in on-hook ring mode");

  chk_ring_sense_ones: assert property (@(posedge clk_sys) disable iff (rst)
    (rzh_b && sense_in.ring_event && sense_in.line_present) |=> (sense_q == LMR_SENSE_ONES))
    else $error("sense not all ones during ring with voltage");

  chk_ring_sense_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (rzh_b && sense_in.ring_event && !sense_in.line_present) |=> (sense_q == LMR_SENSE_ZERO))
    else $error("sense not all zeroes during ring without voltage");

  chk_force_no_restart: assert property (@(posedge clk_sys) disable iff (rst)
    ($past(state_q) == LMR_FORCE_ONHOOK) && state_q[1] |-> !offhook_restart)
    else $error("off-hook counter restarted after force on-hook");

  chk_fast_dct_entry: assert property (@(posedge clk_sys) disable iff (rst)
    ({mode_b, hook_b, onhook_monitor_enable_b} == 3'b011 && !(rzh_b && sense_in.ring_event))
      |=> (state_q == LMR_FAST_DCT) && tx_quiet
      && (sense_q == $past(sense_in.loop_current)))
    else $error("fast dc termination not entered");

  chk_half_wave_neg: assert property (@(posedge clk_sys) disable iff (rst)
    (!ctrl_q[LMR_RECT_BIT] && !ring_inputs_pos && ring_inputs_neg) |=> !ring_detect_pin)
    else $error("negative lobe passed in half wave mode");

  chk_squelch_follow: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == LMR_CTRL_OFS) |-> ##2 (ring_squelch_en == $past(reg_wdata[0], 2)))
    else $error("squelch enable does not follow written bit");

  chk_loop_sense_off: assert property (@(posedge clk_sys) disable iff (rst)
    ({mode_b, hook_b, onhook_monitor_enable_b} == 3'b010 && !sense_in.ring_event)
      |=> (sense_q == $past(sense_in.loop_current)) && (state_q == LMR_OFFHOOK))
    else $error("sense field not loop current off-hook");

  chk_write_to_state: assert property (@(posedge clk_sys) disable iff (rst)
    (reg_wr && reg_addr == LMR_HOOK_OFS && reg_wdata[1:0] == 2'b01 && !mode_b)
      |-> ##2 (state_q == LMR_OFFHOOK))
    else $error("hook write did not take line off-hook");

endmodule : lmr_ctrl

`default_nettype wire
